// file: hw/eos_learn_pkg.sv
// Shared constants, register map and types for the learn/alert block.
// Assumes a single 100 MHz clock and a same-clock device core.
package eos_learn_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MASK_COUNT = 7;
  localparam logic [7:0] REG_MASK_BASE = 8'h00;
  localparam logic [7:0] REG_MASK_LAST = 8'h18;
  localparam logic [7:0] REG_CFG = 8'h20;
  localparam logic [7:0] REG_TIMES = 8'h24;
  localparam logic [7:0] REG_PHASE = 8'h28;
  localparam logic [7:0] REG_CHG = 8'h2C;
  localparam logic [7:0] REG_CUR = 8'h30;
  localparam logic [7:0] REG_LEVELS = 8'h34;
  localparam logic [7:0] REG_INIT_RCELL = 8'h38;
  localparam logic [7:0] REG_CMD = 8'h3C;
  localparam logic [7:0] REG_STATUS = 8'h40;
  localparam logic [7:0] REG_RCELL = 8'h44;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_SEQ_BIT = 1;
  localparam int CFG_TEST_BIT = 2;
  localparam int CFG_SLOPE_BIT = 3;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_ABORT_BIT = 1;
  localparam int CMD_TOGGLE_BIT = 2;
  localparam int CMD_RELOAD_BIT = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [3:0] CFG_RST = 4'h0;
  localparam logic [31:0] TIMES_RST = 32'h3C3C_05A0;
  localparam logic [31:0] PHASE_RST = 32'h0708_003C;
  localparam logic [31:0] CHG_RST = 32'h02D0_0032;
  localparam logic [31:0] CUR_RST = 32'h0032_01F4;
  localparam logic [31:0] LEVELS_RST = 32'h0810_1820;
  localparam logic [15:0] INIT_RCELL_RST = 16'h0064;
  // Writable bits per mask; reserved bits stay zero
  localparam logic [7:0] MASK_VALID [MASK_COUNT] =
    '{8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hDF, 8'h77, 8'h03};

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int ONE_SEC_NS = 1000000000;
  localparam int SEC_CYCLES = ONE_SEC_NS / CLK_PERIOD_NS;
  localparam logic [5:0] SEC_PER_MIN = 6'h3C;
  localparam logic [15:0] TEST_AUTO_MIN = 16'h000A;
  localparam logic [15:0] TEST_AW_MIN = 16'h000A;
  localparam logic [7:0] TEST_MIN_LEARN_MIN = 8'h0A;
  localparam logic [7:0] TEST_RETRY_MIN = 8'h05;
  localparam logic [15:0] RATIO_ONE = 16'h0010;
  localparam logic [15:0] SLOPE_SCALE = 16'h003C;
  localparam logic [1:0] SLOPE_MIN_PHASES = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_CHARGE, ST_RELAX, ST_DISCHARGE, ST_EVALUATE
  } learn_state_e;

  typedef struct packed {
    logic [15:0] battery_status;
    logic [7:0] learn_status_hi;
    logic [7:0] service_status;
    logic [1:0] op_status;
    logic [15:0] charge_voltage_mv;
    logic charge_done;
    logic relaxed;
    logic start_permit;
    logic signed [15:0] current_ma;
    logic [15:0] rcell;
    logic power_event;
  } core_in_s;

  typedef struct packed {
    logic enable;
    logic seq_dsg_first;
    logic test_timers;
    logic slope_en;
    logic [15:0] auto_min;
    logic [7:0] retry_min;
    logic [7:0] min_learn_min;
    logic [15:0] dsg_sec;
    logic [15:0] relax_sec;
    logic [15:0] chg_delta_mv;
    logic [15:0] aw_min;
    logic [15:0] cur_ma;
    logic [15:0] cur_tol;
    logic [7:0] ratio_alert;
    logic [7:0] ratio_warn;
    logic [7:0] slope_alert;
    logic [7:0] slope_warn;
    logic [15:0] init_rcell;
  } learn_cfg_s;

endpackage

// file: hw/eos_learn_alert_control.sv
// Learn-phase sequencer, resistance judgement and masked alert output.
// Assumes all core inputs and the register port run on clk.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps

module eos_learn_alert_control
  import eos_learn_pkg::*;
#(
  parameter int SEC_CYCLES_P = SEC_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  input wire core_in_s core,
  output logic learn_load_enable,
  output logic learn_charge_active,
  output logic [15:0] learn_charge_target_mv,
  output logic alert
);

  if (SEC_CYCLES_P < 2) begin : g_bad_sec
    $error("SEC_CYCLES_P must be at least 2");
  end

  localparam int SEC_W = $clog2(SEC_CYCLES_P);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic mul_gt(input logic [15:0] a,
                                  input logic [15:0] b,
                                  input logic [15:0] c,
                                  input logic [15:0] d);
    logic [31:0] lhs;
    logic [31:0] rhs;
    lhs = a * b;
    rhs = c * d;
    return lhs > rhs;
  endfunction

  function automatic learn_cfg_s build_cfg(input logic [3:0] cfg,
                                           input logic [31:0] times,
                                           input logic [31:0] phase,
                                           input logic [31:0] charging_flag,
                                           input logic [31:0] cur,
                                           input logic [31:0] lvl,
                                           input logic [15:0] init);
    learn_cfg_s c;
    c.enable = cfg[CFG_ENABLE_BIT];
    c.seq_dsg_first = cfg[CFG_SEQ_BIT];
    c.test_timers = cfg[CFG_TEST_BIT];
    c.slope_en = cfg[CFG_SLOPE_BIT];
    c.auto_min = times[15:0];
    c.retry_min = times[23:16];
    c.min_learn_min = times[31:24];
    c.dsg_sec = phase[15:0];
    c.relax_sec = phase[31:16];
    c.chg_delta_mv = charging_flag[15:0];
    c.aw_min = charging_flag[31:16];
    c.cur_ma = cur[15:0];
    c.cur_tol = cur[31:16];
    c.ratio_alert = lvl[7:0];
    c.ratio_warn = lvl[15:8];
    c.slope_alert = lvl[23:16];
    c.slope_warn = lvl[31:24];
    c.init_rcell = init;
    return c;
  endfunction

  localparam learn_cfg_s CFG_DEFAULT = build_cfg(CFG_RST, TIMES_RST,
    PHASE_RST, CHG_RST, CUR_RST, LEVELS_RST, INIT_RCELL_RST);

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  logic [7:0] mask_q [MASK_COUNT];
  logic [3:0] cfg_q;
  logic [31:0] times_q, phase_q, chg_q, cur_q, levels_q;
  logic [15:0] init_q;
  learn_cfg_s act_q;
  logic mask_hit;
  logic cmd_wr, start_cmd, abort_cmd, toggle_cmd, reload_cmd;

  assign mask_hit = (addr >= REG_MASK_BASE) && (addr <= REG_MASK_LAST)
                    && (addr[1:0] == 2'h0);
  assign cmd_wr = wr && (addr == REG_CMD);
  assign start_cmd = cmd_wr && wdata[CMD_START_BIT];
  assign abort_cmd = cmd_wr && wdata[CMD_ABORT_BIT];
  assign toggle_cmd = cmd_wr && wdata[CMD_TOGGLE_BIT];
  assign reload_cmd = cmd_wr && wdata[CMD_RELOAD_BIT];

  // Mask registers, reserved bits held at zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < MASK_COUNT; i++) begin
        mask_q[i] <= MASK_RST;
      end
    end else if (wr && mask_hit) begin
      mask_q[addr[4:2]] <= wdata[7:0] & MASK_VALID[addr[4:2]];
    end
  end

  // Stored configuration
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= CFG_RST;
      times_q <= TIMES_RST;
      phase_q <= PHASE_RST;
      chg_q <= CHG_RST;
      cur_q <= CUR_RST;
      levels_q <= LEVELS_RST;
      init_q <= INIT_RCELL_RST;
    end else if (toggle_cmd) begin
      cfg_q[CFG_ENABLE_BIT] <= ~act_q.enable;
    end else if (wr) begin
      case (addr)
        REG_CFG: cfg_q <= wdata[3:0];
        REG_TIMES: times_q <= wdata;
        REG_PHASE: phase_q <= wdata;
        REG_CHG: chg_q <= wdata;
        REG_CUR: cur_q <= wdata;
        REG_LEVELS: levels_q <= wdata;
        REG_INIT_RCELL: init_q <= wdata[15:0];
        default: ;
      endcase
    end
  end

  // Working copy; stored edits apply only on reload, except the enable toggle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act_q <= CFG_DEFAULT;
    end else if (reload_cmd) begin
      act_q <= build_cfg(cfg_q, times_q, phase_q, chg_q, cur_q,
                         levels_q, init_q);
    end else if (toggle_cmd) begin
      act_q.enable <= ~act_q.enable;
    end
  end

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  logic [SEC_W-1:0] sec_cnt_q;
  logic [5:0] min_cnt_q;
  logic sec_tick, min_tick;

  assign sec_tick = (sec_cnt_q == SEC_W'(SEC_CYCLES_P - 1));
  assign min_tick = sec_tick && (min_cnt_q == SEC_PER_MIN - 6'h01);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sec_cnt_q <= '0;
      min_cnt_q <= '0;
    end else begin
      sec_cnt_q <= sec_tick ? '0 : sec_cnt_q + SEC_W'(1);
      if (min_tick) begin
        min_cnt_q <= '0;
      end else if (sec_tick) begin
        min_cnt_q <= min_cnt_q + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Start, retry and stop events
  // ----------------------------------------------------------------
  learn_state_e state_q;
  logic [15:0] phase_sec_q, elapsed_min_q, last_rcell_q;
  logic [7:0] retry_min_q;
  logic retry_pend_q, ever_learned_q, fault_q, abort_q, cmd_q;
  logic ratio_alert_q, ratio_warn_q, slope_alert_q, slope_warn_q;
  logic [1:0] good_cnt_q;
  logic [15:0] eff_auto, eff_aw, interval;
  logic [7:0] eff_retry, eff_min_learn;
  logic in_phase, auto_due, retry_due, start_req, ev_begin, ev_blocked;
  logic ev_abort, ev_fault, ev_stop, ev_success, slope_ok;
  logic signed [17:0] cur_err;
  logic [17:0] cur_abs;

  assign eff_auto = act_q.test_timers ? TEST_AUTO_MIN : act_q.auto_min;
  assign eff_aw = act_q.test_timers ? TEST_AW_MIN : act_q.aw_min;
  assign eff_retry = act_q.test_timers ? TEST_RETRY_MIN
                                       : act_q.retry_min;
  assign eff_min_learn = act_q.test_timers ? TEST_MIN_LEARN_MIN
                                           : act_q.min_learn_min;
  assign interval = (ratio_alert_q || ratio_warn_q || slope_alert_q
                     || slope_warn_q) ? eff_aw : eff_auto;

  assign in_phase = (state_q != ST_IDLE);
  assign auto_due = (act_q.auto_min != 16'h0000)
                    && (elapsed_min_q >= interval);
  assign retry_due = retry_pend_q && (retry_min_q >= eff_retry);
  assign start_req = act_q.enable && !in_phase
                     && (start_cmd || auto_due || retry_due);
  assign ev_begin = start_req && core.start_permit;
  assign ev_blocked = start_req && !core.start_permit;
  assign ev_abort = abort_cmd && in_phase;

  // Learn current is negative; compare its size to the intended value
  assign cur_err = -18'(core.current_ma) - $signed({2'b00, act_q.cur_ma});
  assign cur_abs = cur_err[17] ? 18'(-cur_err) : 18'(cur_err);
  assign ev_fault = (state_q == ST_DISCHARGE) && sec_tick
                    && (phase_sec_q != 16'h0000)
                    && (cur_abs > {2'b00, act_q.cur_tol})
                    && !ev_abort;
  assign ev_stop = ev_abort || ev_fault || (in_phase && !act_q.enable);
  assign ev_success = (state_q == ST_EVALUATE) && !ev_stop;

  // ----------------------------------------------------------------
  // Learn sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      phase_sec_q <= '0;
    end else if (ev_stop) begin
      state_q <= ST_IDLE;
      phase_sec_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          phase_sec_q <= '0;
          if (ev_begin) begin
            state_q <= act_q.seq_dsg_first ? ST_RELAX
                                           : ST_CHARGE;
          end
        end
        ST_CHARGE: begin
          if (core.charge_done) begin
            state_q <= ST_RELAX;
          end
        end
        ST_RELAX: begin
          if (core.relaxed && phase_sec_q >= act_q.relax_sec) begin
            state_q <= ST_DISCHARGE;
            phase_sec_q <= '0;
          end else if (sec_tick && phase_sec_q != 16'hFFFF) begin
            phase_sec_q <= phase_sec_q + 16'h0001;
          end
        end
        ST_DISCHARGE: begin
          if (sec_tick) begin
            if (phase_sec_q + 16'h0001 >= act_q.dsg_sec) begin
              state_q <= ST_EVALUATE;
            end else begin
              phase_sec_q <= phase_sec_q + 16'h0001;
            end
          end
        end
        ST_EVALUATE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Load and charge pins follow the phase; host switches the load from this
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      learn_load_enable <= 1'b0;
      learn_charge_active <= 1'b0;
      learn_charge_target_mv <= '0;
    end else begin
      learn_load_enable <= (state_q == ST_DISCHARGE);
      learn_charge_active <= (state_q == ST_CHARGE);
      // Separate output; stored charge voltages are not touched
      learn_charge_target_mv <= core.charge_voltage_mv
                                + act_q.chg_delta_mv;
    end
  end

  // ----------------------------------------------------------------
  // Retry and elapsed-time counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      retry_pend_q <= 1'b0;
      retry_min_q <= '0;
    end else if (ev_blocked || ev_abort || ev_fault) begin
      retry_pend_q <= 1'b1;
      retry_min_q <= '0;
    end else if (ev_begin || !act_q.enable) begin
      retry_pend_q <= 1'b0;
      retry_min_q <= '0;
    end else if (retry_pend_q && min_tick && retry_min_q != 8'hFF) begin
      retry_min_q <= retry_min_q + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      elapsed_min_q <= '0;
    end else if (ev_success) begin
      elapsed_min_q <= '0;
    end else if (min_tick && elapsed_min_q != 16'hFFFF) begin
      elapsed_min_q <= elapsed_min_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Learn status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ever_learned_q <= 1'b0;
      fault_q <= 1'b0;
      abort_q <= 1'b0;
      cmd_q <= 1'b0;
    end else begin
      if (ev_success) begin
        ever_learned_q <= 1'b1;
      end
      // Clear on a new start, then any event of this cycle wins
      if (ev_begin) begin
        fault_q <= 1'b0;
        abort_q <= 1'b0;
      end
      if (ev_fault || ev_blocked) begin
        fault_q <= 1'b1;
      end
      if (ev_abort) begin
        abort_q <= 1'b1;
      end
      if (ev_success) begin
        cmd_q <= 1'b0;
      end
      if (start_cmd && act_q.enable) begin
        cmd_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Resistance judgement
  // ----------------------------------------------------------------
  logic [15:0] r_delta;

  assign r_delta = (core.rcell > last_rcell_q) ? core.rcell - last_rcell_q
                                               : 16'h0000;
  assign slope_ok = act_q.slope_en && (good_cnt_q >= SLOPE_MIN_PHASES)
                    && (elapsed_min_q >= {8'h00, eff_min_learn});

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ratio_alert_q <= 1'b0;
      ratio_warn_q <= 1'b0;
      slope_alert_q <= 1'b0;
      slope_warn_q <= 1'b0;
      last_rcell_q <= '0;
    end else if (ev_success) begin
      ratio_alert_q <= mul_gt(core.rcell, RATIO_ONE, act_q.init_rcell,
                              {8'h00, act_q.ratio_alert});
      ratio_warn_q <= mul_gt(core.rcell, RATIO_ONE, act_q.init_rcell,
                             {8'h00, act_q.ratio_warn});
      slope_alert_q <= slope_ok && mul_gt(r_delta, SLOPE_SCALE,
        elapsed_min_q, {8'h00, act_q.slope_alert});
      slope_warn_q <= slope_ok && mul_gt(r_delta, SLOPE_SCALE,
        elapsed_min_q, {8'h00, act_q.slope_warn});
      last_rcell_q <= core.rcell;
    end
  end

  // Phases completed under continuous power
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      good_cnt_q <= '0;
    end else if (core.power_event) begin
      good_cnt_q <= '0;
    end else if (ev_success && good_cnt_q != SLOPE_MIN_PHASES) begin
      good_cnt_q <= good_cnt_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Status bytes and alert
  // ----------------------------------------------------------------
  logic [7:0] learn_lo, safety;
  logic [7:0] stat [MASK_COUNT];
  logic any_masked;

  assign learn_lo = {!ever_learned_q, fault_q, abort_q, cmd_q,
                     in_phase && !cmd_q, state_q == ST_RELAX,
                     state_q == ST_CHARGE,
                     state_q == ST_DISCHARGE};
  assign safety = {2'b00, slope_warn_q, ratio_warn_q,
                   2'b00, slope_alert_q, ratio_alert_q};

  always_comb begin
    stat[0] = core.battery_status[7:0];
    stat[1] = core.battery_status[15:8];
    stat[2] = learn_lo;
    stat[3] = core.learn_status_hi;
    stat[4] = core.service_status;
    stat[5] = safety;
    stat[6] = {6'h00, core.op_status};
    any_masked = 1'b0;
    for (int i = 0; i < MASK_COUNT; i++) begin
      any_masked = any_masked | (|(stat[i] & mask_q[i]));
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alert <= 1'b0;
    end else begin
      alert <= any_masked;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    if (mask_hit) begin
      rd_mux = {24'h000000, mask_q[addr[4:2]]};
    end else begin
      case (addr)
        REG_CFG: rd_mux = {28'h0000000, cfg_q};
        REG_TIMES: rd_mux = times_q;
        REG_PHASE: rd_mux = phase_q;
        REG_CHG: rd_mux = chg_q;
        REG_CUR: rd_mux = cur_q;
        REG_LEVELS: rd_mux = levels_q;
        REG_INIT_RCELL: rd_mux = {16'h0000, init_q};
        REG_STATUS: rd_mux = {9'h000, good_cnt_q, retry_pend_q,
                              act_q.enable, state_q, safety, learn_lo};
        REG_RCELL: rd_mux = {elapsed_min_q, last_rcell_q};
        default: rd_mux = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= '0;
    end else begin
      rdata <= rd ? rd_mux : '0;
    end
  end

endmodule // eos_learn_alert_control

// file: verif/eos_learn_alert_control_properties.sv
// Port checker for bus, alert and learn-load timing.
// Assumes one clock; bound into the block below.
`timescale 1ns/1ps
module eos_learn_alert_control_properties
  import eos_learn_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire core_in_s core,
  input wire logic learn_load_enable,
  input wire logic learn_charge_active,
  input wire logic [15:0] learn_charge_target_mv,
  input wire logic alert
);
  logic [7:0] m0_q;
  // ----
  // Shadow of first mask
  // ----
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) m0_q <= 8'h00;
    else if (wr && addr == REG_MASK_BASE) m0_q <= wdata[7:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  rdata_idle_a: assert property (
    !$past(rd) |-> rdata == 32'h0) else $error("rdata not idle");
  unmapped_zero_a: assert property (
    rd && addr > 8'h44 |=> rdata == 32'h0) else $error("unmapped read");
  mask_upper_a: assert property (
    rd && addr <= REG_MASK_LAST |=> rdata[31:8] == 24'h0)
    else $error("mask upper bits set");
  rsvd_bit_a: assert property (
    rd && addr == 8'h04 |=> !rdata[7]) else $error("reserved bit set");
  alert_or_a: assert property (
    (core.battery_status[7:0] & m0_q) != 8'h00 |=> alert)
    else $error("masked status gave no alert");
  reset_quiet_a: assert property (
    !$past(rstn) |-> !alert && !learn_load_enable && !learn_charge_active)
    else $error("outputs active after reset");
  charge_relax_a: assert property (
    $fell(learn_charge_active) |-> !learn_load_enable)
    else $error("load right after charge");
  load_hold_a: assert property (
    !(wr && addr == REG_CMD) ##1
    ($rose(learn_load_enable) && !(wr && addr == REG_CMD))
    |-> learn_load_enable [*3])
    else $error("load pulse too short");
  load_after_relax_a: assert property (
    $rose(learn_load_enable) |-> $past(core.relaxed, 2))
    else $error("load before relax");
endmodule // eos_learn_alert_control_properties

bind eos_learn_alert_control eos_learn_alert_control_properties chk_u (
  .clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .core,
  .learn_load_enable, .learn_charge_active, .learn_charge_target_mv,
  .alert);

// file: verif/learn_host_model.sv
// Host side: external learn load, charger end and cell relax.
// Assumes the bench supplies all other core fields.
`timescale 1ns/1ps
module learn_host_model
  import eos_learn_pkg::*;
#(
  parameter logic signed [15:0] LOAD_MA = 16'sh01F4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic learn_load_enable,
  input wire logic learn_charge_active,
  input wire core_in_s core_i,
  output core_in_s core_o
);
  logic [3:0] chg_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) chg_q <= 4'h0;
    else if (!learn_charge_active) chg_q <= 4'h0;
    else if (chg_q != 4'hF) chg_q <= chg_q + 4'h1;
  end
  always_comb begin
    core_o = core_i;
    core_o.current_ma = learn_load_enable ? -LOAD_MA : 16'sh0000;
    core_o.charge_done = chg_q > 4'h4;
    // Idle cell counts as relaxed; no extra discharge needed
    core_o.relaxed = !learn_load_enable && !learn_charge_active;
  end
endmodule // learn_host_model

// file: verif/tb_eos_learn_alert_control.sv
// Bench: registers, alert, both learn orders, one abort (charge first) and one current fault.
// Assumes the host model at the far side, 10 cycles a second.
`timescale 1ns/1ps
module tb_eos_learn_alert_control import eos_learn_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic [31:0] rdata;
  core_in_s cin = '0;
  core_in_s core_w;
  logic load_en, chg_act, alert;
  logic [15:0] tgt;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  logic [7:0] r;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 67;
  int n;
  always #5 clk = ~clk;
  eos_learn_alert_control #(.SEC_CYCLES_P(10)) dut_u (.clk, .rstn, .addr,
    .wdata, .wr, .rd, .rdata, .core(core_w), .learn_load_enable(load_en),
    .learn_charge_active(chg_act), .learn_charge_target_mv(tgt), .alert);
  learn_host_model host_u (.clk, .rstn, .learn_load_enable(load_en),
    .learn_charge_active(chg_act), .core_i(cin), .core_o(core_w));
  task automatic check(input logic [31:0] got, input logic [31:0] x);
    n_tests++;
    if (got !== x) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, x);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [63:0] xm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(xm);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic wait_sig(input bit sel, input logic want);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((sel ? chg_act : load_en) !== want && n < 400);
    check(32'(n < 400), 32'h1);
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----
  // Read watcher and timeout
  // ----
  always @(posedge clk) begin
    rd_q <= rd;
    cyc++;
    if (rd_q && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check(rdata & e[31:0], e[63:32]);
    end
    if (cyc == 5000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    cin.start_permit = 1'b1;
    cin.charge_voltage_mv = 16'h1004;
    cin.rcell = 16'h00C9;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < MASK_COUNT; i++) begin
      r = 8'($random(seed));
      rreg(8'(i * 4), 64'hFFFF_FFFF);
      wreg(8'(i * 4), {24'h0, r});
      rreg(8'(i * 4), {24'h0, r & MASK_VALID[i], 32'hFFFF_FFFF});
      wreg(8'(i * 4), 32'h0);
    end
    rreg(8'h80, 64'hFFFF_FFFF);
    r = 8'($random(seed)) | 8'h01;
    wreg(REG_MASK_BASE, {24'h0, r});
    cin.battery_status <= {8'hFF, ~r};
    repeat (3) @(negedge clk);
    check(32'(alert), 32'h0);
    @(posedge clk);
    cin.battery_status <= {8'h00, r};
    repeat (3) @(negedge clk);
    check(32'(alert), 32'h1);
    @(posedge clk);
    cin.battery_status <= 16'h0000;
    wreg(REG_CFG, 32'h2);
    wreg(REG_PHASE, 32'h3);
    wreg(REG_CMD, 32'h8);
    wreg(REG_CMD, 32'h4);
    wreg(REG_CMD, 32'h1);
    wait_sig(1'b0, 1'b1);
    check(32'(chg_act), 32'h0);
    wait_sig(1'b0, 1'b0);
    check(32'(n >= 20 && n <= 40), 32'h1);
    repeat (4) @(posedge clk);
    rreg(REG_STATUS, 64'h0000_1100_0007_3300);
    wreg(REG_CFG, 32'h1);
    wreg(REG_CMD, 32'h8);
    wreg(REG_CMD, 32'h1);
    wait_sig(1'b1, 1'b1);
    check(32'(tgt), 32'h1036);
    wait_sig(1'b0, 1'b1);
    wreg(REG_CMD, 32'h2);
    wait_sig(1'b0, 1'b0);
    check(32'(n < 5), 32'h1);
    rreg(REG_STATUS, 64'h0010_0020_0017_0020);
    wreg(REG_CMD, 32'h4);
    wreg(REG_CMD, 32'h1);
    rreg(REG_STATUS, 64'h000F_0000);
    wreg(REG_CFG, 32'h3);
    wreg(REG_CUR, 32'h0032_0190);
    wreg(REG_CMD, 32'h8);
    wreg(REG_CMD, 32'h1);
    wait_sig(1'b0, 1'b1);
    wait_sig(1'b0, 1'b0);
    check(32'(n >= 11 && n <= 20), 32'h1);
    rreg(REG_STATUS, 64'h0010_0040_0017_0040);
    repeat (2) @(posedge clk);
    give_verdict();
  end
endmodule // tb_eos_learn_alert_control
